// file: core/lr_page_cfg.svh
`ifndef LR_PAGE_CFG_SVH
`define LR_PAGE_CFG_SVH
`define IDX_FIFO 7'h00
`define IDX_OPMODE 7'h01
`define IDX_RSVD_FIRST 7'h02
`define IDX_RSVD_LAST 7'h05
`define IDX_FREQ_HI 7'h06
`define IDX_FREQ_MID 7'h07
`define IDX_SHARED_FIRST 7'h0d
`define IDX_SHARED_LAST 7'h3f
`define BIT_FAMILY 7
`define BIT_SHARED 6
`define BIT_BAND 3
`define RST_FAMILY 1'b0
`define RST_SHARED 1'b0
`define RST_BAND 1'b1
`define RST_MODE 3'h1
`define RST_FIFO_PORT 8'h00
`define RST_FREQ_HI 8'h6c
`define RST_FREQ_MID 8'h80
`define FIFO_DEPTH 256
`define FIFO_AW 8
`endif

// file: core/lr_page_pkg.sv
`default_nettype none
package lr_page_pkg;
   typedef enum logic [2:0] {
      sleep_state = 3'b000,
      standby_state = 3'b001,
      tx_synth_state = 3'b010,
      tx_state = 3'b011,
      rx_synth_state = 3'b100,
      rx_streaming_state = 3'b101,
      rx_one_shot_state = 3'b110,
      channel_activity_check = 3'b111
   } dev_mode_e;
   typedef enum logic [2:0] {
      hit_fifo = 3'b000,
      hit_opmode = 3'b001,
      hit_rsvd = 3'b010,
      hit_freq_hi = 3'b011,
      hit_freq_mid = 3'b100,
      hit_window = 3'b101,
      hit_none = 3'b110
   } hit_e;
   typedef struct packed {
      logic psel;
      logic penable;
      logic pwrite;
      logic [8:0] paddr;
      logic [31:0] pwdata;
   } apb_req_s;
   typedef struct packed {
      logic pready;
      logic [31:0] prdata;
      logic pslverr;
   } apb_rsp_s;
   typedef struct packed {
      logic modem_family_select;
      logic shared_page_select;
      logic band_page_select;
      dev_mode_e mode;
   } op_mode_s;
   typedef struct packed {
      logic [7:0] wr_ptr;
      logic [7:0] rd_ptr;
      logic [8:0] count;
   } fifo_state_s;
   typedef struct packed {
      apb_rsp_s rsp;
      op_mode_s op;
      logic [7:0] freq_high;
      logic [7:0] freq_middle;
      logic pop_armed;
      logic window_access;
      logic fsk_page_active;
      logic mode_trigger;
      logic cad_start;
      logic [7:0] mdm_pop_data;
   } top_state_s;
endpackage
`default_nettype wire

// file: core/baseband_fifo.sv
`include "lr_page_cfg.svh"
`default_nettype none
module baseband_fifo (
   input wire logic clk, // System clock
   input wire logic arst_n, // Async reset, active low
   input wire logic clear, // Drop all contents
   input wire logic push, // Write one byte
   input wire logic [7:0] push_data, // Byte to write
   input wire logic pop, // Remove head byte
   output logic [7:0] head, // Oldest byte
   output logic empty, // No byte held
   output logic full, // No room left
   output logic [8:0] level // Bytes held
);
   lr_page_pkg::fifo_state_s st_reg;
   lr_page_pkg::fifo_state_s st_next;
   logic [7:0] mem [0:`FIFO_DEPTH-1];
   logic do_push;
   logic do_pop;

   // Status from the count flop only
   assign empty = (st_reg.count == 9'h000);
   assign full = (st_reg.count == 9'(`FIFO_DEPTH));
   assign level = st_reg.count;
   assign head = mem[st_reg.rd_ptr];
   // Clear beats both push and pop
   assign do_push = push && !full && !clear;
   assign do_pop = pop && !empty && !clear;

   // Pointer and count update
   always_comb begin
      st_next = st_reg;
      if (clear) begin
         st_next = '0;
      end else begin
         if (do_push) begin
            st_next.wr_ptr = st_reg.wr_ptr + 8'h01;
         end
         if (do_pop) begin
            st_next.rd_ptr = st_reg.rd_ptr + 8'h01;
         end
         st_next.count = st_reg.count + {8'h00, do_push} - {8'h00, do_pop};
      end
   end

   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         st_reg <= '0;
      end else begin
         st_reg <= st_next;
      end
   end

   // Storage needs no reset; unread cells are never seen
   always_ff @(posedge clk) begin
      if (do_push) begin
         mem[st_reg.wr_ptr] <= push_data;
      end
   end
endmodule
`default_nettype wire

// file: core/long_range_mode_register_page.sv
`include "lr_page_cfg.svh"
`default_nettype none
module long_range_mode_register_page (
   input wire logic clk, // System clock, 20 MHz
   input wire logic arst_n, // Async reset, active low
   input wire lr_page_pkg::apb_req_s apb_req, // APB request from master
   output lr_page_pkg::apb_rsp_s apb_rsp, // APB answer
   input wire logic mdm_push, // Modem writes a byte
   input wire logic [7:0] mdm_push_data, // Byte from modem
   input wire logic mdm_pop, // Modem takes a byte
   output logic [7:0] mdm_pop_data, // Byte taken by modem
   output lr_page_pkg::op_mode_s op_mode, // Family, paging, mode
   output logic [7:0] carrier_freq_high, // Frequency bits 23:16
   output logic [7:0] carrier_freq_middle, // Frequency bits 15:8
   output logic mode_trigger, // Pulse on mode write
   output logic cad_start, // Pulse on activity check start
   output logic fsk_page_active, // Upper window shows FSK page
   output logic window_access, // Access pending in upper window
   output logic [8:0] fifo_level // Bytes in FIFO
);
   lr_page_pkg::top_state_s s_reg;
   lr_page_pkg::top_state_s s_next;
   logic [6:0] idx;
   logic access;
   logic capture;
   logic commit;
   logic in_sleep;
   logic host_push;
   logic host_pop;
   logic fifo_push;
   logic [7:0] fifo_push_data;
   logic fifo_pop;
   logic modem_pop_ok;
   logic host_read_capture;
   logic [7:0] fifo_head;
   logic fifo_empty;
   logic [8:0] fifo_count;

   // Register index from a word-aligned byte address
   function automatic lr_page_pkg::hit_e decode(input logic [6:0] i);
      lr_page_pkg::hit_e h;
      h = lr_page_pkg::hit_none;
      if (i == `IDX_FIFO) begin
         h = lr_page_pkg::hit_fifo;
      end else if (i == `IDX_OPMODE) begin
         h = lr_page_pkg::hit_opmode;
      end else if (i >= `IDX_RSVD_FIRST && i <= `IDX_RSVD_LAST) begin
         h = lr_page_pkg::hit_rsvd;
      end else if (i == `IDX_FREQ_HI) begin
         h = lr_page_pkg::hit_freq_hi;
      end else if (i == `IDX_FREQ_MID) begin
         h = lr_page_pkg::hit_freq_mid;
      end else if (i >= `IDX_SHARED_FIRST && i <= `IDX_SHARED_LAST) begin
         h = lr_page_pkg::hit_window;
      end
      return h;
   endfunction

   // Operating-mode byte as software reads it
   function automatic logic [31:0] opmode_word(input lr_page_pkg::op_mode_s o);
      logic [31:0] w;
      w = 32'h0000_0000;
      w[`BIT_FAMILY] = o.modem_family_select;
      w[`BIT_SHARED] = o.shared_page_select;
      w[`BIT_BAND] = o.band_page_select;
      w[2:0] = o.mode; // Bits 5-4 stay zero
      return w;
   endfunction

   // Bus phases: one wait cycle, then the completing edge
   assign idx = apb_req.paddr[8:2];
   assign access = apb_req.psel && apb_req.penable;
   assign capture = access && !s_reg.rsp.pready;
   assign commit = access && s_reg.rsp.pready;
   assign in_sleep = (s_reg.op.mode == lr_page_pkg::sleep_state);

   // Host FIFO traffic is dead in SLEEP
   assign host_push = commit && apb_req.pwrite && !in_sleep
      && (decode(idx) == lr_page_pkg::hit_fifo);
   assign host_pop = commit && !apb_req.pwrite && s_reg.pop_armed;

   // Host wins the FIFO; a clashing modem byte is lost
   assign fifo_push = host_push || (mdm_push && !in_sleep);
   assign fifo_push_data = host_push ? apb_req.pwdata[7:0] : mdm_push_data;

   // Host read captures the head; a modem pop on that edge would hand it out twice
   assign host_read_capture = capture && !apb_req.pwrite
      && (decode(idx) == lr_page_pkg::hit_fifo);

   // Modem may not pop while a host read holds the head
   assign modem_pop_ok = mdm_pop && !host_pop && !s_reg.pop_armed && !host_read_capture
      && !in_sleep && !fifo_empty;
   assign fifo_pop = host_pop || modem_pop_ok;

   baseband_fifo u_fifo (
      .clk(clk),
      .arst_n(arst_n),
      .clear(in_sleep),
      .push(fifo_push),
      .push_data(fifo_push_data),
      .pop(fifo_pop),
      .head(fifo_head),
      .empty(fifo_empty),
      .full(),
      .level(fifo_count)
   );

   // Next state of the whole register page
   always_comb begin
      s_next = s_reg;
      s_next.mode_trigger = 1'b0;
      s_next.cad_start = 1'b0;

      // First access cycle: read data and answer prepared
      if (capture) begin
         s_next.rsp.pready = 1'b1;
         s_next.rsp.pslverr = 1'b0;
         s_next.rsp.prdata = 32'h0000_0000;
         s_next.window_access = 1'b0;
         case (decode(idx))
            lr_page_pkg::hit_fifo: begin
               // Empty or sleeping port reads zero, no pop
               if (!in_sleep && !fifo_empty && !apb_req.pwrite) begin
                  s_next.rsp.prdata = {24'h00_0000, fifo_head};
                  s_next.pop_armed = 1'b1;
               end
            end
            lr_page_pkg::hit_opmode: begin
               s_next.rsp.prdata = opmode_word(s_reg.op);
            end
            lr_page_pkg::hit_rsvd: begin
               s_next.rsp.prdata = 32'h0000_0000;
            end
            lr_page_pkg::hit_freq_hi: begin
               s_next.rsp.prdata = {24'h00_0000, s_reg.freq_high};
            end
            lr_page_pkg::hit_freq_mid: begin
               s_next.rsp.prdata = {24'h00_0000, s_reg.freq_middle};
            end
            lr_page_pkg::hit_window: begin
               // Upper window lives outside this block
               s_next.window_access = 1'b1;
               s_next.rsp.pslverr = 1'b1;
            end
            default: begin
               s_next.rsp.pslverr = 1'b1;
            end
         endcase
      end

      // Completing edge: writes land, answer withdrawn
      if (commit) begin
         s_next.rsp.pready = 1'b0;
         s_next.rsp.pslverr = 1'b0;
         s_next.rsp.prdata = 32'h0000_0000;
         s_next.pop_armed = 1'b0;
         s_next.window_access = 1'b0;
         if (apb_req.pwrite) begin
            case (decode(idx))
               lr_page_pkg::hit_opmode: begin
                  // Family bit judged against the mode before this write
                  if (in_sleep) begin
                     s_next.op.modem_family_select =
                        apb_req.pwdata[`BIT_FAMILY];
                  end
                  s_next.op.shared_page_select =
                     apb_req.pwdata[`BIT_SHARED];
                  s_next.op.band_page_select =
                     apb_req.pwdata[`BIT_BAND];
                  s_next.op.mode =
                     lr_page_pkg::dev_mode_e'(apb_req.pwdata[2:0]);
                  s_next.mode_trigger = 1'b1;
                  s_next.cad_start = (apb_req.pwdata[2:0]
                     == lr_page_pkg::channel_activity_check);
               end
               lr_page_pkg::hit_freq_hi: begin
                  s_next.freq_high = apb_req.pwdata[7:0];
               end
               lr_page_pkg::hit_freq_mid: begin
                  s_next.freq_middle = apb_req.pwdata[7:0];
               end
               default: begin
                  // FIFO handled by the buffer; reserved writes do nothing
                  s_next.freq_high = s_reg.freq_high;
               end
            endcase
         end
      end

      // Byte handed to the modem on its pop
      if (modem_pop_ok) begin
         s_next.mdm_pop_data = fifo_head;
      end

      // Page seen in the upper window follows the new settings
      s_next.fsk_page_active = !s_next.op.modem_family_select
         || s_next.op.shared_page_select;
   end

   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         s_reg.rsp <= '0;
         s_reg.op.modem_family_select <= `RST_FAMILY;
         s_reg.op.shared_page_select <= `RST_SHARED;
         s_reg.op.band_page_select <= `RST_BAND;
         s_reg.op.mode <= lr_page_pkg::dev_mode_e'(`RST_MODE);
         s_reg.freq_high <= `RST_FREQ_HI;
         s_reg.freq_middle <= `RST_FREQ_MID;
         s_reg.pop_armed <= 1'b0;
         s_reg.window_access <= 1'b0;
         s_reg.fsk_page_active <= 1'b1;
         s_reg.mode_trigger <= 1'b0;
         s_reg.cad_start <= 1'b0;
         s_reg.mdm_pop_data <= `RST_FIFO_PORT;
      end else begin
         s_reg <= s_next;
      end
   end

   // Outputs straight from the state flops
   assign apb_rsp = s_reg.rsp;
   assign op_mode = s_reg.op;
   assign carrier_freq_high = s_reg.freq_high;
   assign carrier_freq_middle = s_reg.freq_middle;
   assign mode_trigger = s_reg.mode_trigger;
   assign cad_start = s_reg.cad_start;
   assign fsk_page_active = s_reg.fsk_page_active;
   assign window_access = s_reg.window_access;
   assign mdm_pop_data = s_reg.mdm_pop_data;
   assign fifo_level = fifo_count; // Count flop inside the buffer
endmodule
`default_nettype wire

// file: verification/lr_page_monitor.sv
`default_nettype none
module lr_page_monitor (
   input wire logic clk, // Clock
   input wire logic arst_n, // Reset, active low
   input wire lr_page_pkg::apb_req_s apb_req, // Bus request
   input wire lr_page_pkg::apb_rsp_s apb_rsp, // Bus answer
   input wire lr_page_pkg::op_mode_s op_mode, // Mode register
   input wire logic mode_trigger, // Mode pulse
   input wire logic cad_start, // Check pulse
   input wire logic fsk_page_active, // Page flag
   input wire logic window_access, // Window hit
   input wire logic [8:0] fifo_level // Bytes held
);
   default clocking cb @(posedge clk); endclocking
   default disable iff (!arst_n);
   // Word index and commit edge of a transfer
   wire logic [6:0] idx = apb_req.paddr[8:2];
   wire logic done = apb_req.psel & apb_req.penable & apb_rsp.pready;
   // Bus timing and data shape
   a_answer_one_wait: assert property (apb_req.psel && !apb_req.penable |=>
      !apb_rsp.pready ##1 apb_rsp.pready) else $error("pready not in second access cycle");
   a_pready_single: assert property (apb_rsp.pready |=> !apb_rsp.pready)
      else $error("pready held too long");
   a_data_upper_zero: assert property (apb_rsp.prdata[31:8] == 24'h00_0000
      && (apb_rsp.pready || apb_rsp.prdata == 32'h0000_0000)) else $error("prdata outside byte");
   // Address decode
   a_window_error: assert property (done && idx inside {[7'h0d:7'h3f]} |->
      window_access && apb_rsp.pslverr) else $error("window access not flagged");
   a_rsvd_read_zero: assert property (done && !apb_req.pwrite
      && idx inside {[2:5]} |-> apb_rsp.prdata == 32'h0000_0000 && !apb_rsp.pslverr)
      else $error("reserved not zero");
   // Mode field side effects
   a_trigger_on_write: assert property (done && apb_req.pwrite && idx == 7'h01 |=>
      mode_trigger) else $error("no mode pulse");
   a_cad_mode_match: assert property (cad_start |-> mode_trigger &&
      op_mode.mode == lr_page_pkg::channel_activity_check) else $error("bad check pulse");
   a_family_in_sleep: assert property ($changed(op_mode.modem_family_select) |->
      $past(op_mode.mode) == lr_page_pkg::sleep_state) else $error("family changed awake");
   // Flag comes from the same next state as the settings, so it never lags
   a_page_flag: assert property (fsk_page_active ==
      (!op_mode.modem_family_select || op_mode.shared_page_select)) else $error("page flag");
   a_sleep_empty: assert property (op_mode.mode == lr_page_pkg::sleep_state |=>
      fifo_level == 9'h000) else $error("FIFO kept in sleep");
   c_cad: cover property (cad_start);
   c_window: cover property (done && window_access);
   c_family: cover property ($rose(op_mode.modem_family_select));
endmodule
bind long_range_mode_register_page lr_page_monitor mon (.clk(clk), .arst_n(arst_n),
   .apb_req(apb_req), .apb_rsp(apb_rsp), .op_mode(op_mode), .mode_trigger(mode_trigger),
   .cad_start(cad_start), .fsk_page_active(fsk_page_active), .window_access(window_access),
   .fifo_level(fifo_level));
`default_nettype wire

// file: verification/long_range_mode_register_page_bench.sv
`default_nettype none
module long_range_mode_register_page_bench;
   timeunit 1ns;
   timeprecision 1ns;
   logic clk = 1'b0;
   logic arst_n = 1'b0;
   lr_page_pkg::apb_req_s req = '0;
   lr_page_pkg::apb_rsp_s rsp;
   logic push = 1'b0;
   logic [7:0] push_d = 8'h00;
   logic pop = 1'b0;
   logic [7:0] pop_d;
   lr_page_pkg::op_mode_s op;
   logic [7:0] f_hi, f_mid;
   logic trig, cad, fsk, win;
   logic [8:0] lvl;
   int err_count = 0;
   int n_tests = 0;
   int n_trig = 0;
   int n_cad = 0;
   int n_win = 0;
   int nw = 0;
   logic [31:0] seed = 32'h325b_cd9c;
   logic [31:0] rd;
   logic e;
   logic [7:0] cur = 8'h09;
   logic [7:0] d;
   logic [7:0] q [$];
   logic [7:0] rv [8] = '{8'h00, 8'h09, 8'h00, 8'h00, 8'h00, 8'h00, 8'h6c, 8'h80};
   // Clock, 50 ns period
   always #25 clk = ~clk;
   // One-cycle pulses are counted here so that no check can miss them
   always @(posedge clk) begin
      if (trig === 1'b1) n_trig <= n_trig + 1;
      if (cad === 1'b1) n_cad <= n_cad + 1;
      if (win === 1'b1) n_win <= n_win + 1;
   end
   long_range_mode_register_page dut (.clk(clk), .arst_n(arst_n), .apb_req(req),
      .apb_rsp(rsp), .mdm_push(push), .mdm_push_data(push_d), .mdm_pop(pop),
      .mdm_pop_data(pop_d), .op_mode(op), .carrier_freq_high(f_hi),
      .carrier_freq_middle(f_mid), .mode_trigger(trig), .cad_start(cad),
      .fsk_page_active(fsk), .window_access(win), .fifo_level(lvl));
   // Fixed-seed xorshift
   function logic [7:0] rnd();
      seed ^= seed << 13;
      seed ^= seed >> 17;
      seed ^= seed << 5;
      return seed[7:0];
   endfunction
   // Family bit moves only when the old mode was sleep
   function logic [7:0] next_op(input logic [7:0] c, input logic [7:0] w);
      return {(c[2:0] == 3'b000) ? w[7] : c[7], w[6], 2'b00, w[3:0]};
   endfunction
   task print_verdict();
      $display("Comparisons %0d, mismatches %0d", n_tests, err_count);
      if (err_count == 0 && n_tests > 0) $display("All tests passed");
      else $display("Some tests failed");
      $finish;
   endtask
   task check(input logic [31:0] seen, input logic [31:0] exp);
      n_tests++;
      if (seen !== exp) begin
         $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
         err_count++;
      end
   endtask
   // One transfer; returns a cycle after release so outputs have settled
   task apb(input logic w, input logic [6:0] i, input logic [7:0] wd);
      int n;
      n = 0;
      @(posedge clk);
      req.psel <= 1'b1;
      req.penable <= 1'b0;
      req.pwrite <= w;
      req.paddr <= {i, 2'b00};
      req.pwdata <= {24'h00_0000, wd};
      @(posedge clk);
      req.penable <= 1'b1;
      do begin
         @(posedge clk);
         n++;
      end while (rsp.pready !== 1'b1 && n < 20);
      rd = rsp.prdata;
      e = rsp.pslverr;
      req.psel <= 1'b0;
      req.penable <= 1'b0;
      if (n >= 20) begin
         err_count++;
         print_verdict();
      end else begin
         @(posedge clk);
         #1;
      end
   endtask
   // One modem pulse, pop or push
   task modem(input logic is_pop, input logic [7:0] b);
      @(posedge clk);
      pop <= is_pop;
      push <= !is_pop;
      push_d <= b;
      @(posedge clk);
      pop <= 1'b0;
      push <= 1'b0;
      #1;
   endtask
   initial begin
      repeat (2) @(posedge clk);
      arst_n <= 1'b1;
      // Reset values
      for (int i = 0; i < 8; i++) begin
         apb(1'b0, i[6:0], 8'h00);
         check(rd, {24'h00_0000, rv[i]});
      end
      // Random writes while still in standby; reserved places stay zero
      for (int i = 2; i < 8; i++) begin
         d = rnd();
         apb(1'b1, i[6:0], d);
         if (i == 6) check(f_hi, d);
         if (i == 7) check(f_mid, d);
         apb(1'b0, i[6:0], 8'h00);
         check(rd, (i < 6) ? 32'h0000_0000 : {24'h00_0000, d});
      end
      // Every mode, family from count bit 3, random page and reserved bits
      for (int i = 0; i < 24; i++) begin
         d = rnd();
         d[2:0] = i[2:0];
         // Family asked for both after an awake mode and after sleep
         d[7] = i[3];
         apb(1'b1, 7'h01, d);
         cur = next_op(cur, d);
         check(op, {cur[7:6], cur[3:0]});
         check(fsk, !cur[7] | cur[6]);
         apb(1'b0, 7'h01, 8'h00);
         check(rd, cur);
      end
      check(n_trig, 32'h0000_0018);
      check(n_cad, 32'h0000_0003);
      // FIFO order across host and modem
      for (int i = 0; i < 4; i++) begin
         d = rnd();
         q.push_back(d);
         apb(1'b1, 7'h00, d);
      end
      check(lvl, 9'h004);
      modem(1'b1, 8'h00);
      check(pop_d, q.pop_front());
      for (int i = 0; i < 4; i++) begin
         apb(1'b0, 7'h00, 8'h00);
         check(rd, (i < 3) ? q.pop_front() : 8'h00);
      end
      d = rnd();
      modem(1'b0, d);
      apb(1'b0, 7'h00, 8'h00);
      check(rd, d);
      // Sleep drops FIFO content and blocks the port
      apb(1'b1, 7'h00, rnd());
      apb(1'b1, 7'h01, 8'h00);
      check(lvl, 9'h000);
      apb(1'b1, 7'h00, 8'h77);
      apb(1'b0, 7'h00, 8'h00);
      check(rd, 32'h0000_0000);
      // Upper window edges and unmapped places answer error
      for (int i = 0; i < 8; i++) begin
         d = (i == 0) ? 8'h0d : (i == 1) ? 8'h3f : 8'h08 + rnd() % 8'h78;
         if (d >= 8'h0d && d <= 8'h3f) nw++;
         apb(i[0], d[6:0], rnd());
         check(rd, 32'h0000_0000);
         check(e, 1'b1);
      end
      check(n_win, nw);
      print_verdict();
   end
endmodule
`default_nettype wire
